// ---- hdl/sft_pkg.sv ----
// Constants for the supply fault timing and debounce block.
// Assumes a 20 MHz core clock and a 32-bit AHB-Lite register bus.
package sft_pkg;
  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_FREQ_HZ / 1_000_000 * TICK_US;
  localparam int US_PER_MS = 1000;
  localparam int MS_PER_S = 1000;

  // ----------------------------------------
  // Delay tables
  // ----------------------------------------
  localparam int OCP_STEP_S = 1;
  localparam int OCP_FAST_MS = 50;
  localparam int OVP_FILT_US = 15;
  localparam int UVP_FILT_US = 450;
  localparam int POWER_ON_REQUEST_DEB_MS [4] = '{80, 0, 40, 160};
  localparam int ON_DLY_MS [4] = '{400, 200, 800, 1600};
  localparam int OFF_DLY_MS [4] = '{2, 0, 1, 4};

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [5:0] IDX_OTP_TRIM = 6'h0b;
  localparam logic [5:0] IDX_POWER_ON_REQUEST_CFG = 6'h0e;
  localparam logic [5:0] IDX_MON_CFG = 6'h0f;
  localparam logic [5:0] IDX_OFF_CFG = 6'h10;
  localparam logic [5:0] IDX_FAST_CFG = 6'h11;
  localparam logic [5:0] IDX_OCP_CFG = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  localparam logic [5:0] IDX_MASK = 6'h21;
  localparam logic [5:0] IDX_PIN_CFG = 6'h22;
  localparam logic [5:0] IDX_LIVE = 6'h23;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [8:0] PIN_CFG_RST = 9'h000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OTP_TRIM_LSB = 4;
  localparam int ON_DLY_LSB = 0;
  localparam int POWER_ON_REQUEST_FN_LSB = 2;
  localparam int DEB_LSB = 0;
  localparam int FIFTH_MONITOR_INPUT_FN_LSB = 2;
  localparam int PG_FN_LSB = 5;
  localparam int OFF_DLY_LSB = 6;
  localparam int FAST_BIT = 2;
  localparam int OCP_DLY_LSB = 3;
  localparam int PIN_STYLE_LSB = 4;
  localparam int POWER_ON_REQUEST_INV_BIT = 8;

  // ----------------------------------------
  // Function codes
  // ----------------------------------------
  localparam logic [2:0] FIFTH_MONITOR_INPUT_OVP_A = 3'h2;
  localparam logic [2:0] FIFTH_MONITOR_INPUT_OVP_B = 3'h4;
  localparam logic [2:0] FIFTH_MONITOR_INPUT_UVP_A = 3'h3;
  localparam logic [2:0] FIFTH_MONITOR_INPUT_UVP_B = 3'h5;
  localparam logic [1:0] FN_OTP_A = 2'h1;
  localparam logic [1:0] FN_OTP_B = 2'h2;
  localparam logic [1:0] FN_PIN_USE = 2'h0;

  // ----------------------------------------
  // Timers, events, pins
  // ----------------------------------------
  localparam int NT = 6;
  localparam int T_OCP = 0;
  localparam int T_OVP = 1;
  localparam int T_UVP = 2;
  localparam int T_POWER_ON_REQUEST = 3;
  localparam int T_ON = 4;
  localparam int T_OFF = 5;
  localparam int NEV = 6;
  localparam int NPIN = 4;
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
endpackage : sft_pkg

// ---- hdl/sft_qual_timer.sv ----
// Qualifying timer: reports a condition once it has held for a set count of ticks.
// Assumes a one-cycle tick enable from the parent's divider.
`timescale 1ns/100ps
`default_nettype none
module sft_qual_timer
#(
  parameter int CNT_W = 23
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic cond,
  input wire logic [CNT_W-1:0] limit,
  output logic done
);
  initial
  begin
    if (CNT_W < 2 || CNT_W > 31) $error("sft_qual_timer: CNT_W out of range");
  end

  typedef struct packed {
    logic armed;
    logic fin;
    logic [CNT_W-1:0] lim;
    logic [CNT_W-1:0] cnt;
  } sft_tmr_t;

  sft_tmr_t st_ff;
  sft_tmr_t nxt_st;

  // --------------------------------------
  // Interval sequencing
  // --------------------------------------
  // Limit is latched when the interval opens, so later edits wait for the next one
  always_comb
  begin
    nxt_st = st_ff;
    if (!cond)
    begin
      nxt_st = '0;
    end
    else if (!st_ff.armed)
    begin
      nxt_st.armed = 1'b1;
      nxt_st.lim = limit;
      nxt_st.cnt = '0;
      nxt_st.fin = (limit == '0);
    end
    else if (!st_ff.fin && tick)
    begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
      nxt_st.fin = (st_ff.cnt + 1'b1 >= st_ff.lim);
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign done = st_ff.fin;
endmodule : sft_qual_timer
`default_nettype wire

// ---- hdl/sft_core.sv ----
// Supply fault timing: shutdown delays, monitor filters, request debounce,
// power-good delays, pin drive styles and the three-level address strap.
// Assumes synchronous pin inputs, analog comparators outside, AHB-Lite access.
//
// Behaviour
// - Slow mode: shut down after 1, 2, 3 or 4 s of current limit.
// - Fast mode: overcurrent shutdown within a short delay under 100 ms.
// - Overvoltage mode on fifth monitor ignores excursions shorter than its filter.
// - Undervoltage mode on fifth monitor ignores excursions shorter than its filter.
// - Overtemperature sensing active for function codes 01x or 10x, trim four bits.
// - Power-on request debounced 80, 0, 40 or 160 ms by a two-bit code.
// - Power-good asserts 400, 200, 800 or 1600 ms after power is good.
// - Power-good deasserts 2, 0, 1 or 4 ms after power is lost.
// - Address strap read as low, floating or high.
// - Four outputs drive as pull-down when on or source high when on.
// - Each output selects N or P open-drain style and normal or inverted polarity.
// - Logic truth follows the signal name, not the pin level.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module sft_core
  import sft_pkg::*;
#(
  parameter int CYC_PER_TICK = TICK_CYC,
  parameter int TICK_PER_MS = US_PER_MS,
  parameter int CNT_W = 23
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic current_limit_in,
  input wire logic fifth_monitor_input,
  input wire logic otp_hot_in,
  input wire logic power_on_request,
  input wire logic power_ok_in,
  input wire logic mains_ok_in,
  input wire logic strap_above_low,
  input wire logic strap_above_high,
  output logic power_enable_out_o,
  output logic power_enable_out_oe,
  output logic power_good_out_o,
  output logic power_good_out_oe,
  output logic circuit_breaker_out_o,
  output logic circuit_breaker_out_oe,
  output logic mains_good_out_o,
  output logic mains_good_out_oe,
  output logic otp_sense_en,
  output logic [3:0] otp_trim,
  output logic [1:0] strap_address_bit
);
  initial
  begin
    if (CYC_PER_TICK < 1 || CYC_PER_TICK > 256) $error("sft_core: CYC_PER_TICK out of range");
    if (TICK_PER_MS < 1) $error("sft_core: TICK_PER_MS out of range");
    if (CNT_W < 23 || CNT_W > 31) $error("sft_core: CNT_W too small for longest delay");
  end

  typedef struct packed {
    logic dph_wr;
    logic dph_rd;
    logic [5:0] dph_idx;
    logic [31:0] rdata;
    logic [7:0] otp_cfg;
    logic [7:0] power_on_request_cfg;
    logic [7:0] mon_cfg;
    logic [7:0] off_cfg;
    logic [7:0] fast_cfg;
    logic [7:0] ocp_cfg;
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
    logic [8:0] pin_cfg;
    logic [7:0] tick_cnt;
    logic tick;
    logic shutdown;
    logic pgood;
    logic strap_done;
    logic [1:0] strap;
    logic [NPIN-1:0] pin_o;
    logic [NPIN-1:0] pin_oe;
  } sft_state_t;

  sft_state_t st_ff;
  sft_state_t nxt_st;
  logic [NT-1:0] t_cond;
  logic [NT-1:0] t_done;
  logic [CNT_W-1:0] t_limit [NT];

  // --------------------------------------
  // Delay conversion
  // --------------------------------------
  // Milliseconds to ticks of the time base
  function automatic logic [CNT_W-1:0] ms_ticks(input int ms);
    ms_ticks = CNT_W'(ms * TICK_PER_MS);
  endfunction : ms_ticks

  // Microseconds to ticks, never below one tick
  function automatic logic [CNT_W-1:0] us_ticks(input int us);
    int t;
    t = (us * TICK_PER_MS) / US_PER_MS;
    us_ticks = CNT_W'((t < 1) ? 1 : t);
  endfunction : us_ticks

  // --------------------------------------
  // Decoded configuration
  // --------------------------------------
  logic [2:0] fifth_monitor_input_fn;
  logic [2:0] pg_fn;
  logic [2:0] power_on_request_fn;
  logic ovp_mode;
  logic uvp_mode;
  logic otp_mode;
  logic pg_used;
  logic power_on_request_used;
  logic req_q;
  logic pwr_en;
  logic pwr_good;
  logic ovp_fault;
  logic uvp_fault;
  logic otp_fault;
  logic [NPIN-1:0] pin_act;

  // Function fields and monitor modes
  assign fifth_monitor_input_fn = st_ff.mon_cfg[FIFTH_MONITOR_INPUT_FN_LSB +: 3];
  assign pg_fn = st_ff.mon_cfg[PG_FN_LSB +: 3];
  assign power_on_request_fn = st_ff.power_on_request_cfg[POWER_ON_REQUEST_FN_LSB +: 3];
  assign ovp_mode = (fifth_monitor_input_fn == FIFTH_MONITOR_INPUT_OVP_A) || (fifth_monitor_input_fn == FIFTH_MONITOR_INPUT_OVP_B);
  assign uvp_mode = (fifth_monitor_input_fn == FIFTH_MONITOR_INPUT_UVP_A) || (fifth_monitor_input_fn == FIFTH_MONITOR_INPUT_UVP_B);
  assign otp_mode = (fifth_monitor_input_fn[2:1] == FN_OTP_A) || (fifth_monitor_input_fn[2:1] == FN_OTP_B);
  assign pg_used = (pg_fn[2:1] == FN_PIN_USE);
  assign power_on_request_used = (power_on_request_fn[2:1] == FN_PIN_USE);

  // Request, enable and fault levels
  assign req_q = power_on_request_used ? t_done[T_POWER_ON_REQUEST] : 1'b1;
  assign pwr_en = req_q & ~st_ff.shutdown;
  assign pwr_good = power_ok_in & pwr_en;
  assign ovp_fault = ovp_mode & t_done[T_OVP];
  assign uvp_fault = uvp_mode & t_done[T_UVP];
  assign otp_fault = otp_mode & otp_hot_in;

  // --------------------------------------
  // Timer conditions and limits
  // --------------------------------------
  always_comb
  begin
    t_cond[T_OCP] = current_limit_in & pwr_en;
    t_cond[T_OVP] = ovp_mode & fifth_monitor_input;
    t_cond[T_UVP] = uvp_mode & fifth_monitor_input;
    t_cond[T_POWER_ON_REQUEST] = power_on_request ^ st_ff.pin_cfg[POWER_ON_REQUEST_INV_BIT];
    t_cond[T_ON] = pwr_good & ~st_ff.pgood;
    t_cond[T_OFF] = ~pwr_good & st_ff.pgood;
    if (st_ff.fast_cfg[FAST_BIT])
      t_limit[T_OCP] = ms_ticks(OCP_FAST_MS);
    else
      t_limit[T_OCP] = ms_ticks(OCP_STEP_S * MS_PER_S * (int'(st_ff.ocp_cfg[OCP_DLY_LSB +: 2]) + 1));
    t_limit[T_OVP] = us_ticks(OVP_FILT_US);
    t_limit[T_UVP] = us_ticks(UVP_FILT_US);
    t_limit[T_POWER_ON_REQUEST] = ms_ticks(POWER_ON_REQUEST_DEB_MS[st_ff.mon_cfg[DEB_LSB +: 2]]);
    t_limit[T_ON] = ms_ticks(ON_DLY_MS[st_ff.power_on_request_cfg[ON_DLY_LSB +: 2]]);
    t_limit[T_OFF] = ms_ticks(OFF_DLY_MS[st_ff.off_cfg[OFF_DLY_LSB +: 2]]);
  end

  // One qualifying timer per monitored interval
  for (genvar i = 0; i < NT; i++)
  begin : g_tmr
    sft_qual_timer #(.CNT_W(CNT_W)) u_tmr
    (
      .core_clk(core_clk),
      .rst(rst),
      .tick(st_ff.tick),
      .cond(t_cond[i]),
      .limit(t_limit[i]),
      .done(t_done[i])
    );
  end

  // Logic level of each output: enable, power-good, breaker, mains-good
  assign pin_act = {mains_ok_in, st_ff.shutdown, st_ff.pgood & pg_used, pwr_en};

  // --------------------------------------
  // Next state
  // --------------------------------------
  always_comb
  begin
    logic [NEV-1:0] ev;
    logic [NEV-1:0] clr;
    logic asrt;
    nxt_st = st_ff;
    ev = '0;
    clr = '0;
    asrt = 1'b0;

    // Time base: one tick every CYC_PER_TICK cycles
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt == 8'(CYC_PER_TICK - 1))
    begin
      nxt_st.tick_cnt = 8'h00;
      nxt_st.tick = 1'b1;
    end
    else
      nxt_st.tick_cnt = st_ff.tick_cnt + 8'h01;

    // Shutdown latch, released when the request drops
    if (!req_q)
      nxt_st.shutdown = 1'b0;
    else if (pwr_en && (t_done[T_OCP] || ovp_fault || uvp_fault || otp_fault))
      nxt_st.shutdown = 1'b1;
    ev[0] = pwr_en & t_done[T_OCP];
    ev[1] = pwr_en & ovp_fault;
    ev[2] = pwr_en & uvp_fault;
    ev[3] = pwr_en & otp_fault;

    // Power-good on and off delays
    if (t_done[T_ON])
      nxt_st.pgood = 1'b1;
    else if (t_done[T_OFF])
      nxt_st.pgood = 1'b0;
    ev[4] = t_done[T_ON];
    ev[5] = t_done[T_OFF];

    // Strap caught once after reset release
    if (!st_ff.strap_done)
    begin
      nxt_st.strap_done = 1'b1;
      if (strap_above_high)
        nxt_st.strap = STRAP_HIGH;
      else if (strap_above_low)
        nxt_st.strap = STRAP_FLOAT;
      else
        nxt_st.strap = STRAP_LOW;
    end

    // Output drive: on-level after polarity, then pull-down or source high
    for (int p = 0; p < NPIN; p++)
    begin
      asrt = pin_act[p] ^ st_ff.pin_cfg[p];
      nxt_st.pin_oe[p] = asrt;
      nxt_st.pin_o[p] = st_ff.pin_cfg[PIN_STYLE_LSB + p];
    end

    // Bus data phase: writes land here
    if (st_ff.dph_wr)
    begin
      unique case (st_ff.dph_idx)
        IDX_OTP_TRIM: nxt_st.otp_cfg = hwdata[7:0];
        IDX_POWER_ON_REQUEST_CFG: nxt_st.power_on_request_cfg = hwdata[7:0];
        IDX_MON_CFG: nxt_st.mon_cfg = hwdata[7:0];
        IDX_OFF_CFG: nxt_st.off_cfg = hwdata[7:0];
        IDX_FAST_CFG: nxt_st.fast_cfg = hwdata[7:0];
        IDX_OCP_CFG: nxt_st.ocp_cfg = hwdata[7:0];
        IDX_STATUS: clr = hwdata[NEV-1:0];
        IDX_MASK: nxt_st.mask = hwdata[NEV-1:0];
        IDX_PIN_CFG: nxt_st.pin_cfg = hwdata[8:0];
        default: ;
      endcase
    end
    // Sticky events: a set in the clearing cycle wins
    nxt_st.status = (st_ff.status & ~clr) | ev;

    // Bus address phase: read data prepared for the data phase
    nxt_st.dph_wr = 1'b0;
    nxt_st.dph_rd = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    if (hsel && htrans[1] && hready)
    begin
      nxt_st.dph_wr = hwrite;
      nxt_st.dph_rd = ~hwrite;
      nxt_st.dph_idx = haddr[7:2];
      if (!hwrite)
      begin
        unique case (haddr[7:2])
          IDX_OTP_TRIM: nxt_st.rdata[7:0] = st_ff.otp_cfg;
          IDX_POWER_ON_REQUEST_CFG: nxt_st.rdata[7:0] = st_ff.power_on_request_cfg;
          IDX_MON_CFG: nxt_st.rdata[7:0] = st_ff.mon_cfg;
          IDX_OFF_CFG: nxt_st.rdata[7:0] = st_ff.off_cfg;
          IDX_FAST_CFG: nxt_st.rdata[7:0] = st_ff.fast_cfg;
          IDX_OCP_CFG: nxt_st.rdata[7:0] = st_ff.ocp_cfg;
          IDX_STATUS: nxt_st.rdata[NEV-1:0] = st_ff.status;
          IDX_MASK: nxt_st.rdata[NEV-1:0] = st_ff.mask;
          IDX_PIN_CFG: nxt_st.rdata[8:0] = st_ff.pin_cfg;
          IDX_LIVE: nxt_st.rdata[7:0] = {st_ff.strap, req_q, pwr_en, st_ff.shutdown, st_ff.pgood,
                                          otp_mode, fifth_monitor_input};
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------
  // State register
  // --------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.otp_cfg <= CFG_RST;
      st_ff.power_on_request_cfg <= CFG_RST;
      st_ff.mon_cfg <= CFG_RST;
      st_ff.off_cfg <= CFG_RST;
      st_ff.fast_cfg <= CFG_RST;
      st_ff.ocp_cfg <= CFG_RST;
      st_ff.pin_cfg <= PIN_CFG_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // --------------------------------------
  // Outputs
  // --------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign irq = |(st_ff.status & st_ff.mask);
  assign power_enable_out_o = st_ff.pin_o[0];
  assign power_enable_out_oe = st_ff.pin_oe[0];
  assign power_good_out_o = st_ff.pin_o[1];
  assign power_good_out_oe = st_ff.pin_oe[1];
  assign circuit_breaker_out_o = st_ff.pin_o[2];
  assign circuit_breaker_out_oe = st_ff.pin_oe[2];
  assign mains_good_out_o = st_ff.pin_o[3];
  assign mains_good_out_oe = st_ff.pin_oe[3];
  assign otp_sense_en = otp_mode;
  assign otp_trim = st_ff.otp_cfg[OTP_TRIM_LSB +: 4];
  assign strap_address_bit = st_ff.strap;
endmodule : sft_core
`default_nettype wire

// ---- verification/sft_core_assertions.sv ----
// Port checker for the supply fault timing block.
// Assumes default polarity on the enable, power-good and breaker pins.
`timescale 1ns/100ps
`default_nettype none
module sft_core_assertions
#(
  parameter int CYC_PER_TICK = 20,
  parameter int TICK_PER_MS = 1000
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic current_limit_in,
  input wire logic fifth_monitor_input,
  input wire logic otp_hot_in,
  input wire logic power_ok_in,
  input wire logic power_enable_out_oe,
  input wire logic power_good_out_oe,
  input wire logic circuit_breaker_out_oe,
  input wire logic otp_sense_en,
  input wire logic [3:0] otp_trim,
  input wire logic [1:0] strap_address_bit
);
  localparam int OFF_MAX = 4 * TICK_PER_MS * CYC_PER_TICK + 12;
  logic wr_take;
  logic [31:0] pg_hold_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Accepted write request
  assign wr_take = hsel & htrans[1] & hready & hwrite;
  // Cycles that power-good stays on after the enable pin has dropped
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pg_hold_ff <= 32'h0000_0000;
    else if (power_enable_out_oe || !power_good_out_oe)
      pg_hold_ff <= 32'h0000_0000;
    else
      pg_hold_ff <= pg_hold_ff + 32'h0000_0001;
  end
  // Bus and enable steps
  sequence s_rd_gap;
    !(hsel && htrans[1] && hready && !hwrite);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_idle: assert property (s_rd_gap |=> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  a_strap_legal: assert property (strap_address_bit != 2'h3)
    else $error("strap reading has no meaning");
  a_trim_write: assert property ($changed(otp_trim) |-> $past(wr_take, 2))
    else $error("trim changed without a write");
  a_otp_write: assert property ($changed(otp_sense_en) |-> $past(wr_take, 2))
    else $error("sense mode changed without a write");
  a_breaker_excl: assert property (circuit_breaker_out_oe |-> !power_enable_out_oe)
    else $error("enable on while breaker on");
  a_pg_cause: assert property ($rose(power_good_out_oe) |-> $past(power_ok_in, 2))
    else $error("power good rose without good supply");
  a_pg_fall_bound: assert property (pg_hold_ff <= OFF_MAX)
    else $error("power good held too long after enable drop");
  a_trip_cause: assert property ($rose(circuit_breaker_out_oe) |->
    $past(current_limit_in, 2) || $past(fifth_monitor_input, 2) || $past(otp_hot_in, 2))
    else $error("shutdown without a fault");
endmodule : sft_core_assertions
bind sft_core sft_core_assertions #(.CYC_PER_TICK(CYC_PER_TICK), .TICK_PER_MS(TICK_PER_MS))
  sft_core_assertions_inst (.core_clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .current_limit_in, .fifth_monitor_input, .otp_hot_in, .power_ok_in, .power_enable_out_oe,
  .power_good_out_oe, .circuit_breaker_out_oe, .otp_sense_en, .otp_trim, .strap_address_bit);
`default_nettype wire

// ---- verification/sft_supply_model.sv ----
// Supply rail model: output voltage follows the enable pin with lag.
// Assumes the enable pin on state is drive enabled.
`timescale 1ns/100ps
`default_nettype none
module sft_supply_model
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pen_on,
  output logic power_ok_in
);
  logic [6:0] cnt_ff;
  // Rail rises 20 cycles after enable, decays 60 cycles after release
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 7'h00;
      power_ok_in <= 1'b0;
    end
    else if (pen_on == power_ok_in)
      cnt_ff <= 7'h00;
    else if (cnt_ff == (pen_on ? 7'h14 : 7'h3c))
    begin
      cnt_ff <= 7'h00;
      power_ok_in <= pen_on;
    end
    else
      cnt_ff <= cnt_ff + 7'h01;
  end
endmodule : sft_supply_model
`default_nettype wire

// ---- verification/supply_fault_timing_and_debounce_test.sv ----
// Self-checking bench: registers, delays, filters, pins, interrupt.
// Assumes a shortened time base of 8 cycles per millisecond.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module supply_fault_timing_and_debounce_test
  import sft_pkg::*;
  ;
  localparam int CPT = 2;
  localparam int TPM = 4;
  localparam int MS = CPT * TPM;
  localparam int TOL = 6;
  logic core_clk, rst, hsel, hwrite, hreadyout, hresp, irq, otp_sense_en;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [1:0] htrans, strap_address_bit;
  logic [2:0] hsize;
  logic [3:0] otp_trim;
  logic current_limit_in, fifth_monitor_input, otp_hot_in, power_on_request, power_ok_in, mains_ok_in;
  logic strap_above_low, strap_above_high, power_enable_out_o, power_enable_out_oe;
  logic power_good_out_o, power_good_out_oe, circuit_breaker_out_o, circuit_breaker_out_oe;
  logic mains_good_out_o, mains_good_out_oe;
  int n_fail, samples_checked, n, e, lvl;
  logic [7:0] regs [9] = '{8'h2c, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h80, 8'h84, 8'h88};
  logic [2:0] fc [4] = '{3'h2, 3'h4, 3'h3, 3'h5};
  sft_core #(.CYC_PER_TICK(CPT), .TICK_PER_MS(TPM)) sft_core_inst (.core_clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .current_limit_in,
    .fifth_monitor_input, .otp_hot_in, .power_on_request, .power_ok_in, .mains_ok_in, .strap_above_low,
    .strap_above_high, .power_enable_out_o, .power_enable_out_oe, .power_good_out_o, .power_good_out_oe,
    .circuit_breaker_out_o, .circuit_breaker_out_oe, .mains_good_out_o, .mains_good_out_oe, .otp_sense_en,
    .otp_trim, .strap_address_bit);
  sft_supply_model sft_supply_model_inst (.core_clk, .rst, .pen_on(power_enable_out_oe), .power_ok_in);
  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Random source and expectation helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function int fit(int m, int x);
    return (m >= x - TOL && m <= x + TOL) ? x : m;
  endfunction : fit
  function logic pick(int s);
    case (s)
      0: return power_enable_out_oe;
      1: return power_good_out_oe;
      2: return circuit_breaker_out_oe;
      default: return power_ok_in;
    endcase
  endfunction : pick
  task end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // One AHB-Lite single transfer; read data lands in r
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++k < 50);
    if (k >= 50) k = 100;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++k < 100);
    r = hrdata;
    if (k >= 100)
    begin
      n_fail++;
      end_sim();
    end
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
    @(posedge core_clk);
  endtask : wr
  task wt(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim)
    begin
      n_fail++;
      end_sim();
    end
  endtask : wt
  // Main sequence
  initial
  begin
    seed = 32'h4abf_56c3;
    {rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 68'h0, 3'h2};
    {current_limit_in, fifth_monitor_input, otp_hot_in, power_on_request} = 4'h0;
    mains_ok_in = 1'b1;
    lvl = rnd() % 3;
    strap_above_low = (lvl != 0);
    strap_above_high = (lvl == 2);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(strap_address_bit, 2'(lvl))
    foreach (regs[i])
    begin
      bus(1'b0, regs[i], 32'h0);
      `CHK(r, 32'h0000_0000)
    end
    wr(12'h100, rnd());
    bus(1'b0, 12'h100, 32'h0);
    `CHK(r, 32'h0000_0000)
    e = rnd();
    wr(8'h2c, e);
    `CHK(otp_trim, e[7:4])
    bus(1'b0, 8'h2c, 32'h0);
    `CHK(r, {24'h00_0000, e[7:0]})
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h3c, (i << 2) | 1);
      `CHK(otp_sense_en, 1'(i / 2 == 1 || i / 2 == 2))
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h3c, i);
      power_on_request <= 1'b1;
      wt(0, 1'b1, 1500);
      `CHK(fit(n, POWER_ON_REQUEST_DEB_MS[i] * MS), POWER_ON_REQUEST_DEB_MS[i] * MS)
      power_on_request <= 1'b0;
      wt(3, 1'b0, 300);
    end
    wr(8'h3c, 1);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h38, i);
      wr(8'h40, i << 6);
      power_on_request <= 1'b1;
      wt(3, 1'b1, 500);
      wt(1, 1'b1, 14000);
      `CHK(fit(n, ON_DLY_MS[i] * MS), ON_DLY_MS[i] * MS)
      if (i == 0)
      begin
        bus(1'b0, 8'h80, 32'h0);
        `CHK({r[4], irq}, 2'h2)
        wr(8'h84, 32'h10);
        `CHK(irq, 1'b1)
        wr(8'h80, 32'h3f);
        `CHK(irq, 1'b0)
        wr(8'h84, 32'h0);
      end
      power_on_request <= 1'b0;
      wt(0, 1'b0, 50);
      wt(1, 1'b0, 200);
      `CHK(fit(n, OFF_DLY_MS[i] * MS), OFF_DLY_MS[i] * MS)
      wt(3, 1'b0, 300);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h44, (i == 2) ? 4 : 0);
      wr(8'h48, (i % 2) << 3);
      power_on_request <= 1'b1;
      wt(0, 1'b1, 100);
      if (i == 2)
      begin
        current_limit_in <= 1'b1;
        repeat (300) @(posedge core_clk);
        current_limit_in <= 1'b0;
        repeat (10) @(posedge core_clk);
      end
      current_limit_in <= 1'b1;
      wt(2, 1'b1, 17000);
      e = (i == 2) ? OCP_FAST_MS * MS : (i + 1) * OCP_STEP_S * MS_PER_S * MS;
      `CHK(fit(n, e), e)
      `CHK(1'(n <= 100 * MS || i < 2), 1'b1)
      current_limit_in <= 1'b0;
      bus(1'b0, 8'h80, 32'h0);
      `CHK(r[0], 1'b1)
      wr(8'h80, 32'h3f);
      power_on_request <= 1'b0;
      wt(2, 1'b0, 50);
      wt(3, 1'b0, 300);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h3c, (fc[i] << 2) | 1);
      power_on_request <= 1'b1;
      wt(3, 1'b1, 500);
      fifth_monitor_input <= 1'b1;
      @(posedge core_clk);
      fifth_monitor_input <= 1'b0;
      repeat (20) @(posedge core_clk);
      `CHK(circuit_breaker_out_oe, 1'b0)
      fifth_monitor_input <= 1'b1;
      wt(2, 1'b1, 3000);
      bus(1'b0, 8'h80, 32'h0);
      `CHK(r[2:1], fc[i][0] ? 2'h2 : 2'h1)
      fifth_monitor_input <= 1'b0;
      wr(8'h80, 32'h3f);
      power_on_request <= 1'b0;
      wt(2, 1'b0, 50);
      wt(3, 1'b0, 300);
    end
    wr(8'h88, 32'hf8);
    mains_ok_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK({mains_good_out_oe, mains_good_out_o}, 2'h3)
    `CHK({power_enable_out_o, power_good_out_o, circuit_breaker_out_o}, 3'h7)
    mains_ok_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(mains_good_out_oe, 1'b0)
    wr(8'h3c, 32'h41);
    wr(8'h38, 32'h09);
    wt(0, 1'b1, 100);
    `CHK(power_enable_out_oe, 1'b1)
    repeat (1800) @(posedge core_clk);
    `CHK(power_good_out_oe, 1'b0)
    end_sim();
  end
endmodule : supply_fault_timing_and_debounce_test
`default_nettype wire
